// file: hw/ocp_pkg.sv
// Shared constants of the output compare timer block
package ocp_pkg;
  localparam int CNT_W = 16;
  localparam int WIDE_W = 32;
  localparam int NUM_CHAN = 9;
  localparam int NUM_SYNC = 30;
  localparam int NUM_CLK = 6;
  localparam int EXT_CLK = NUM_CLK - 1;
  localparam int PRE_W = 8;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_START = 16'h0000;
  localparam logic [31:0] WIDE_ONE = 32'h00000001;
  localparam logic [31:0] WIDE_ZERO = 32'h00000000;
  // Compare modes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_CONT = 2'h2;
  localparam logic [1:0] MODE_PWM = 2'h3;
  // Source selects
  localparam logic [2:0] CLK_SEL_SYS = 3'h0;
  localparam logic [4:0] SYNC_FREE = 5'h00;
  // Prescale limits for divide by 1, 4, 8, 64
  localparam logic [3:0][7:0] PRE_LIM = {8'h3f, 8'h07, 8'h03, 8'h00};
  // Register word index within a channel
  localparam logic [2:0] REG_CON1 = 3'h0;
  localparam logic [2:0] REG_CON2 = 3'h1;
  localparam logic [2:0] REG_MAIN = 3'h2;
  localparam logic [2:0] REG_SEC = 3'h3;
  localparam logic [2:0] REG_PER = 3'h4;
  localparam logic [2:0] REG_CNT = 3'h5;
  localparam logic [2:0] REG_STAT = 3'h6;
  // Address decode
  localparam int ADDR_W = 12;
  localparam int WORD_LSB = 2;
  localparam int WORD_MSB = 4;
  localparam int CHAN_LSB = 5;
  localparam int CHAN_MSB = 8;
  // Control field positions
  localparam int MODE_LSB = 0;
  localparam int EN_BIT = 2;
  localparam int CLK_LSB = 4;
  localparam int PRE_LSB = 8;
  localparam int SYNC_LSB = 0;
  localparam int TRIG_BIT = 7;
  localparam int CASC_BIT = 8;
  localparam int OUT_BIT = 0;
  localparam int RUN_BIT = 1;
  localparam int DONE_BIT = 2;
endpackage : ocp_pkg

// file: hw/ocp_clksel.sv
// Clock source select and prescaler giving one count tick
`timescale 1ns/1ps
module ocp_clksel #(
  parameter int EXT_N = ocp_pkg::EXT_CLK
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [EXT_N-1:0] ext_tick,
  input wire logic [2:0] clk_sel,
  input wire logic [1:0] pre_sel,
  output logic tick
);
  typedef struct packed {
    logic [ocp_pkg::PRE_W-1:0] div;
    logic tick;
  } ocp_clk_s;
  ocp_clk_s r;
  ocp_clk_s n;
  logic src;

  always_comb
  begin
    n = r;
    n.tick = 1'b0;
    if (clk_sel == ocp_pkg::CLK_SEL_SYS)
      src = 1'b1;
    else if (32'(clk_sel) <= EXT_N)
      src = ext_tick[clk_sel - 3'h1];
    else
      src = 1'b0;
    if (src)
    begin
      if (r.div >= ocp_pkg::PRE_LIM[pre_sel])
      begin
        n.div = '0;
        n.tick = 1'b1;
      end
      else
        n.div = r.div + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      r <= '0;
    else
      r <= n;
  end

  assign tick = r.tick;
endmodule : ocp_clksel

// file: hw/ocp_sync_source_select.sv
// Sync and trigger source selector
`timescale 1ns/1ps
module ocp_sync_source_select #(
  parameter int SRC_N = ocp_pkg::NUM_SYNC
) (
  input wire logic [SRC_N-1:0] src_evt,
  input wire logic [4:0] sync_sel,
  output logic sync_evt
);
  always_comb
  begin
    if (sync_sel != ocp_pkg::SYNC_FREE && 32'(sync_sel) <= SRC_N)
      sync_evt = src_evt[sync_sel - 5'h01];
    else
      sync_evt = 1'b0;
  end
endmodule : ocp_sync_source_select

// file: hw/ocp_top.sv
// Output compare timer channels with APB register access
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// - Free mode counter wraps all-ones to zero
// - Event when counter equals either compare
// - Sync mode runs as soon as clocked
// - Sync event resets counter to start
// - Trigger mode holds counter until sync event
// - Zero sync select means free running
// - Trigger bit picks trigger over sync
// - Odd/even neighbours pair into 32 bits
// - Lower module low half, upper high half
// - Lower rollover increments upper registers
// - PWM period is period value plus one
// - Duty change takes effect at period end
// - All zero compares and period: output low
// - Zero main, secondary above period: output stays high
// - Nine independent compare channels
// - Thirty selectable sync or trigger sources
// - Six clock sources per channel counter
// - Single pulse, continuous pulse and PWM
// - Main and secondary compare per channel
module ocp_top #(
  parameter int NC = ocp_pkg::NUM_CHAN,
  parameter int NS = ocp_pkg::NUM_SYNC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ocp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [ocp_pkg::EXT_CLK-1:0] ext_clk_tick,
  input wire logic [NS-NC-1:0] ext_sync,
  output logic [NC-1:0] compare_output,
  output logic [NC-1:0] compare_event
);
  localparam int IW = $clog2(NC);
  localparam int CW = ocp_pkg::CNT_W;
  localparam int WW = ocp_pkg::WIDE_W;

  typedef struct packed {
    logic [NC-1:0][1:0] mode;
    logic [NC-1:0] en;
    logic [NC-1:0][2:0] clksel;
    logic [NC-1:0][1:0] presc;
    logic [NC-1:0][4:0] sync_source_select;
    logic [NC-1:0] trig;
    logic [NC-1:0] casc;
    logic [NC-1:0][CW-1:0] main_compare_reg;
    logic [NC-1:0][CW-1:0] secondary_compare_reg;
    logic [NC-1:0][CW-1:0] timebase_period_reg;
    logic [NC-1:0][CW-1:0] cnt;
    logic [NC-1:0][CW-1:0] main_l;
    logic [NC-1:0][CW-1:0] sec_l;
    logic [NC-1:0] running;
    logic [NC-1:0] done;
    logic [NC-1:0] out;
    logic [NC-1:0] evt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ocp_state_s;

  ocp_state_s r;
  ocp_state_s n;

  logic [NS-1:0] sync_src;
  logic [NC-1:0] tick;
  logic [NC-1:0] sev;
  logic [NC-1:0] casc_on;
  logic [NC-1:0] up;
  logic [NC-1:0][IW-1:0] hd;
  logic [NC-1:0][WW-1:0] w_cnt;
  logic [NC-1:0][WW-1:0] w_main;
  logic [NC-1:0][WW-1:0] w_sec;
  logic [NC-1:0][WW-1:0] w_per;
  logic [NC-1:0][WW-1:0] w_ml;
  logic [NC-1:0][WW-1:0] w_sl;
  logic [NC-1:0][WW-1:0] wn;
  logic [NC-1:0][WW-1:0] wml_n;
  logic [NC-1:0][WW-1:0] wsl_n;
  logic [NC-1:0] run;
  logic [NC-1:0] adv;
  logic [NC-1:0] srst;
  logic [NC-1:0] pwm;
  logic [NC-1:0] pmatch;
  logic [NC-1:0] latch;
  logic [NC-1:0] hit_m;
  logic [NC-1:0] hit_s;
  logic [NC-1:0] out_n;
  logic [NC-1:0] done_n;
  logic [NC-1:0] run_n;
  logic [IW-1:0] ach;
  logic [2:0] aw;
  logic amap;

  function automatic logic [CW-1:0] half(input logic [WW-1:0] w, input logic hi);
    half = hi ? w[WW-1:CW] : w[CW-1:0];
  endfunction : half

  ////////////////////////////////////////////////////////////////////////////
  // Per channel counter and compare logic

  assign sync_src = {ext_sync, r.evt};

  for (genvar i = 0; i < NC; i++)
  begin : g_ch
    localparam int LO = (i - (i % 2) + 1 < NC) ? i - (i % 2) : i;
    localparam int HI = (LO + 1 < NC) ? LO + 1 : i;
    localparam bit ODD = (i % 2) == 1;

    ocp_clksel #(.EXT_N(ocp_pkg::EXT_CLK)) u_clk (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .ext_tick(ext_clk_tick),
      .clk_sel(r.clksel[i]),
      .pre_sel(r.presc[i]),
      .tick(tick[i])
    );

    ocp_sync_source_select #(.SRC_N(NS)) u_sync (
      .src_evt(sync_src),
      .sync_sel(r.sync_source_select[i]),
      .sync_evt(sev[i])
    );

    // Pair only when both halves ask for it
    assign casc_on[i] = (HI != LO) && r.casc[LO] && r.casc[HI];
    assign up[i] = casc_on[i] && ODD;
    assign hd[i] = casc_on[i] ? IW'(LO) : IW'(i);
    assign w_cnt[i] = casc_on[i] ? {r.cnt[HI], r.cnt[LO]} : {ocp_pkg::CNT_START, r.cnt[i]};
    assign w_main[i] = casc_on[i] ? {r.main_compare_reg[HI], r.main_compare_reg[LO]}
                                  : {ocp_pkg::CNT_START, r.main_compare_reg[i]};
    assign w_sec[i] = casc_on[i] ? {r.secondary_compare_reg[HI], r.secondary_compare_reg[LO]}
                                 : {ocp_pkg::CNT_START, r.secondary_compare_reg[i]};
    assign w_per[i] = casc_on[i] ? {r.timebase_period_reg[HI], r.timebase_period_reg[LO]}
                                 : {ocp_pkg::CNT_START, r.timebase_period_reg[i]};
    assign w_ml[i] = casc_on[i] ? {r.main_l[HI], r.main_l[LO]} : {ocp_pkg::CNT_START, r.main_l[i]};
    assign w_sl[i] = casc_on[i] ? {r.sec_l[HI], r.sec_l[LO]} : {ocp_pkg::CNT_START, r.sec_l[i]};

    assign run[i] = r.en[hd[i]] && (r.sync_source_select[hd[i]] == ocp_pkg::SYNC_FREE
                    || !r.trig[hd[i]] || r.running[hd[i]]);
    assign adv[i] = tick[hd[i]] && run[i];
    assign srst[i] = r.en[hd[i]] && r.sync_source_select[hd[i]] != ocp_pkg::SYNC_FREE && sev[hd[i]];
    assign pwm[i] = r.en[hd[i]] && r.mode[hd[i]] == ocp_pkg::MODE_PWM;
    assign pmatch[i] = pwm[i] && w_cnt[i] == w_per[i];
    // Wide increment carries lower rollover into the upper half
    assign wn[i] = srst[i] ? ocp_pkg::WIDE_ZERO
                 : adv[i] ? (pmatch[i] ? ocp_pkg::WIDE_ZERO : w_cnt[i] + ocp_pkg::WIDE_ONE)
                 : w_cnt[i];
    assign latch[i] = !pwm[i] || srst[i] || (adv[i] && pmatch[i]);
    assign wml_n[i] = latch[i] ? w_main[i] : w_ml[i];
    assign wsl_n[i] = latch[i] ? w_sec[i] : w_sl[i];
    assign hit_m[i] = adv[i] && w_cnt[i] == w_main[i];
    assign hit_s[i] = adv[i] && w_cnt[i] == w_sec[i];
    // Output level per mode
    assign out_n[i] = !r.en[hd[i]] ? 1'b0
                    : pwm[i] ? (wn[i] >= wml_n[i] && wn[i] < wsl_n[i])
                    : r.mode[hd[i]] == ocp_pkg::MODE_OFF ? 1'b0
                    : hit_s[i] ? 1'b0
                    : hit_m[i] ? !(r.mode[hd[i]] == ocp_pkg::MODE_SINGLE && r.done[hd[i]])
                    : r.out[hd[i]];
    assign done_n[i] = r.en[hd[i]] && r.mode[hd[i]] == ocp_pkg::MODE_SINGLE
                       && (r.done[hd[i]] || (r.out[hd[i]] && hit_s[i]));
    assign run_n[i] = r.en[hd[i]] && (r.running[hd[i]] || (r.trig[hd[i]] && srst[i]));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state and APB slave

  assign ach = paddr[ocp_pkg::CHAN_MSB:ocp_pkg::CHAN_LSB];
  assign aw = paddr[ocp_pkg::WORD_MSB:ocp_pkg::WORD_LSB];
  assign amap = paddr[ocp_pkg::ADDR_W-1:ocp_pkg::CHAN_MSB+1] == '0
                && 32'(ach) < NC && aw <= ocp_pkg::REG_STAT;

  always_comb
  begin
    n = r;
    for (int i = 0; i < NC; i++)
    begin
      n.cnt[i] = half(wn[i], up[i]);
      n.main_l[i] = half(wml_n[i], up[i]);
      n.sec_l[i] = half(wsl_n[i], up[i]);
      n.out[i] = out_n[i];
      n.done[i] = done_n[i];
      n.running[i] = run_n[i];
      n.evt[i] = hit_m[i] || hit_s[i];
    end
    n.pready = psel && !penable;
    n.pslverr = 1'b0;
    if (psel && !penable)
    begin
      n.prdata = '0;
      n.pslverr = !amap;
      for (int i = 0; i < NC; i++)
      begin
        if (amap && ach == IW'(i))
        begin
          case (aw)
            ocp_pkg::REG_CON1:
            begin
              n.prdata[ocp_pkg::MODE_LSB +: 2] = r.mode[i];
              n.prdata[ocp_pkg::EN_BIT] = r.en[i];
              n.prdata[ocp_pkg::CLK_LSB +: 3] = r.clksel[i];
              n.prdata[ocp_pkg::PRE_LSB +: 2] = r.presc[i];
            end
            ocp_pkg::REG_CON2:
            begin
              n.prdata[ocp_pkg::SYNC_LSB +: 5] = r.sync_source_select[i];
              n.prdata[ocp_pkg::TRIG_BIT] = r.trig[i];
              n.prdata[ocp_pkg::CASC_BIT] = r.casc[i];
            end
            ocp_pkg::REG_MAIN: n.prdata[CW-1:0] = r.main_compare_reg[i];
            ocp_pkg::REG_SEC: n.prdata[CW-1:0] = r.secondary_compare_reg[i];
            ocp_pkg::REG_PER: n.prdata[CW-1:0] = r.timebase_period_reg[i];
            ocp_pkg::REG_CNT: n.prdata[CW-1:0] = r.cnt[i];
            ocp_pkg::REG_STAT:
            begin
              n.prdata[ocp_pkg::OUT_BIT] = r.out[i];
              n.prdata[ocp_pkg::RUN_BIT] = r.running[i];
              n.prdata[ocp_pkg::DONE_BIT] = r.done[i];
            end
            default: n.prdata = '0;
          endcase
        end
      end
    end
    if (psel && penable && r.pready && pwrite && amap)
    begin
      for (int i = 0; i < NC; i++)
      begin
        if (ach == IW'(i))
        begin
          case (aw)
            ocp_pkg::REG_CON1:
            begin
              n.mode[i] = pwdata[ocp_pkg::MODE_LSB +: 2];
              n.en[i] = pwdata[ocp_pkg::EN_BIT];
              n.clksel[i] = pwdata[ocp_pkg::CLK_LSB +: 3];
              n.presc[i] = pwdata[ocp_pkg::PRE_LSB +: 2];
            end
            ocp_pkg::REG_CON2:
            begin
              n.sync_source_select[i] = pwdata[ocp_pkg::SYNC_LSB +: 5];
              n.trig[i] = pwdata[ocp_pkg::TRIG_BIT];
              n.casc[i] = pwdata[ocp_pkg::CASC_BIT];
            end
            ocp_pkg::REG_MAIN: n.main_compare_reg[i] = pwdata[CW-1:0];
            ocp_pkg::REG_SEC: n.secondary_compare_reg[i] = pwdata[CW-1:0];
            ocp_pkg::REG_PER: n.timebase_period_reg[i] = pwdata[CW-1:0];
            default: n.prdata = r.prdata;
          endcase
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      r <= '0;
    else
      r <= n;
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign compare_output = r.out;
  assign compare_event = r.evt;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on channel 0 and its pair, and on sync, trigger and PWM channels
  localparam int CS = 3;
  localparam int CT = 4;
  localparam int CP = NC - 1;

  chk_free_wrap: assert property (@(posedge ref_clk) disable iff (!reset_n)
    adv[0] && !srst[0] && !pmatch[0] && r.cnt[0] == ocp_pkg::CNT_MAX
    |=> r.cnt[0] == ocp_pkg::CNT_START)
    else $error("counter did not wrap to zero");

  chk_event_match: assert property (@(posedge ref_clk) disable iff (!reset_n)
    adv[0] && w_cnt[0] == w_sec[0] |=> r.evt[0])
    else $error("compare match gave no event");

  chk_sync_start: assert property (@(posedge ref_clk) disable iff (!reset_n)
    r.en[CS] && r.sync_source_select[CS] != ocp_pkg::SYNC_FREE && !r.trig[CS] && tick[CS]
    && !sev[CS] && !pmatch[CS] |=> r.cnt[CS] != $past(r.cnt[CS]))
    else $error("sync mode counter did not run");

  chk_sync_reset: assert property (@(posedge ref_clk) disable iff (!reset_n)
    r.en[CS] && r.sync_source_select[CS] != ocp_pkg::SYNC_FREE && sev[CS]
    |=> r.cnt[CS] == ocp_pkg::CNT_START)
    else $error("sync event did not reset counter");

  chk_trig_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    r.en[CT] && r.trig[CT] && r.sync_source_select[CT] != ocp_pkg::SYNC_FREE && !r.running[CT]
    && !sev[CT] |=> $stable(r.cnt[CT]))
    else $error("trigger mode counter moved before trigger");

  chk_free_mode: assert property (@(posedge ref_clk) disable iff (!reset_n)
    r.en[0] && r.sync_source_select[0] == ocp_pkg::SYNC_FREE && tick[0] && !pmatch[0]
    |=> r.cnt[0] == 16'($past(r.cnt[0]) + 16'h0001))
    else $error("free mode counter did not count");

  chk_trig_select: assert property (@(posedge ref_clk) disable iff (!reset_n)
    r.en[CT] && r.sync_source_select[CT] != ocp_pkg::SYNC_FREE && r.trig[CT] && sev[CT]
    |=> r.running[CT])
    else $error("trigger event did not start counter");

  chk_cascade_inc: assert property (@(posedge ref_clk) disable iff (!reset_n)
    casc_on[0] && adv[0] && !srst[0] && !pmatch[0] && r.cnt[0] == ocp_pkg::CNT_MAX
    |=> r.cnt[1] == 16'($past(r.cnt[1]) + 16'h0001))
    else $error("upper half did not increment on rollover");

  chk_pwm_period: assert property (@(posedge ref_clk) disable iff (!reset_n)
    adv[CP] && pmatch[CP] && !srst[CP] |=> r.cnt[CP] == ocp_pkg::CNT_START)
    else $error("time base did not restart at period");

  chk_duty_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    pwm[CP] && !srst[CP] && !(adv[CP] && pmatch[CP]) |=> $stable(r.sec_l[CP]))
    else $error("duty changed inside a period");

  chk_zero_duty: assert property (@(posedge ref_clk) disable iff (!reset_n)
    pwm[CP] && w_main[CP] == '0 && w_sec[CP] == '0 && w_per[CP] == '0
    && w_ml[CP] == '0 && w_sl[CP] == '0 |=> !r.out[CP])
    else $error("zero duty output went high");

  chk_full_duty: assert property (@(posedge ref_clk) disable iff (!reset_n)
    pwm[CP] && w_sec[CP] > w_per[CP] && w_sl[CP] > w_per[CP] && w_ml[CP] == '0
    && w_main[CP] == '0 && w_cnt[CP] <= w_per[CP] |=> r.out[CP])
    else $error("full duty output went low");
endmodule : ocp_top

// file: sim/ocp_load.sv
// Load model on one compare pin, measuring pulse width and period
`timescale 1ns/1ps
module ocp_load (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic pin,
  output logic rep_valid,
  output logic [15:0] rep_high,
  output logic [15:0] rep_per
);
  logic prev;
  logic seen;
  logic [15:0] hi_cnt;
  logic [15:0] per_cnt;
  ////////////////////////////////////////////////////////////////////////////
  // Report at each rise once a full period has been seen
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prev <= 1'b0;
      seen <= 1'b0;
      hi_cnt <= 16'h0000;
      per_cnt <= 16'h0000;
      rep_valid <= 1'b0;
      rep_high <= 16'h0000;
      rep_per <= 16'h0000;
    end
    else
    begin
      prev <= pin;
      rep_valid <= 1'b0;
      per_cnt <= per_cnt + 16'h0001;
      if (pin)
        hi_cnt <= hi_cnt + 16'h0001;
      if (pin && !prev)
      begin
        rep_valid <= seen;
        rep_high <= hi_cnt;
        rep_per <= per_cnt;
        hi_cnt <= 16'h0001;
        per_cnt <= 16'h0001;
        seen <= 1'b1;
      end
    end
  end
endmodule : ocp_load

// file: sim/test_output_compare_timer_pwm.sv
// Self-checking testbench of the output compare timer block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module test_output_compare_timer_pwm;
  typedef struct {string nm; logic [31:0] e; logic [31:0] m; logic err; bit rel; int sh;} ocp_exp_s;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [4:0] ext_clk_tick = 5'h00;
  logic [20:0] ext_sync = 21'h000000;
  logic [8:0] compare_output;
  logic [8:0] compare_event;
  logic rep_valid;
  logic [15:0] rep_high;
  logic [15:0] rep_per;
  logic [31:0] cyc = 32'h00000000;
  ocp_exp_s aq[$];
  logic [31:0] pq[$];
  ocp_exp_s ex;
  logic [31:0] pe;
  logic [31:0] eq[$];
  logic [31:0] ev_t = 32'h00000000;
  logic ev_seen = 1'b0;
  int n_mismatch = 0;
  int checks_done = 0;
  integer seed = 59;
  ////////////////////////////////////////////////////////////////////////////
  ocp_top u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clk_tick(ext_clk_tick), .ext_sync(ext_sync),
    .compare_output(compare_output), .compare_event(compare_event));
  ocp_load u_load (.ref_clk(ref_clk), .reset_n(reset_n), .pin(compare_output[8]),
    .rep_valid(rep_valid), .rep_high(rep_high), .rep_per(rep_per));
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 32'h1;
  ////////////////////////////////////////////////////////////////////////////
  // Result monitor
  always @(posedge ref_clk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite && aq.size() > 0)
    begin
      ex = aq.pop_front();
      if (ex.rel)
        ex.e = (ex.e + cyc) >> ex.sh;
      `CHK(ex.nm, ex.e & ex.m, prdata & ex.m)
      `CHK({ex.nm, " error"}, ex.err, pslverr)
    end
    if (rep_valid === 1'b1 && pq.size() > 0)
    begin
      pe = pq.pop_front();
      `CHK("pulse", pe, {rep_high, rep_per})
    end
    // Gap between compare events of channel 7
    if (compare_event[7] === 1'b1)
    begin
      if (ev_seen && eq.size() > 0)
      begin
        pe = eq.pop_front();
        `CHK("event gap", pe, cyc - ev_t)
      end
      ev_seen <= 1'b1;
      ev_t <= cyc;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Bus tasks
  function automatic logic [11:0] ad(input int ch, input logic [2:0] w);
    return 12'(ch * 32 + int'(w) * 4);
  endfunction : ad
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd,
    output logic [31:0] rd, output logic [31:0] tc);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      n_mismatch++;
    rd = prdata;
    tc = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input int ch, input logic [2:0] w, input logic [31:0] d);
    logic [31:0] x;
    logic [31:0] t;
    apb(ad(ch, w), 1'b1, d, x, t);
  endtask : wr
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e,
    input logic [31:0] m, input logic err = 1'b0, input bit rel = 0, input int sh = 0);
    logic [31:0] x;
    logic [31:0] t;
    aq.push_back('{nm, e, m, err, rel, sh});
    apb(a, 1'b0, 32'h0, x, t);
  endtask : rd
  task automatic sync_pulse;
    @(posedge ref_clk);
    ext_sync <= {20'($random(seed)), 1'b1};
    @(posedge ref_clk);
    ext_sync <= {20'($random(seed)), 1'b0};
  endtask : sync_pulse
  task test_done;
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    n_mismatch++;
    test_done();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [31:0] d;
    logic [31:0] t;
    logic [31:0] b;
    logic [4:0] sb;
    int n;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    // Reset values, refused and read-only places
    for (int w = 0; w < 7; w++)
      rd("reset value", ad(5, 3'(w)), 32'h0, '1);
    rd("unmapped", 12'h180, 32'h0, '1, 1'b1);
    rd("unmapped", 12'h200, 32'h0, '1, 1'b1);
    wr(5, ocp_pkg::REG_CNT, 32'h1234);
    rd("read only", ad(5, ocp_pkg::REG_CNT), 32'h0, '1);
    for (int w = 2; w < 5; w++)
    begin
      d = $random(seed);
      wr(5, 3'(w), d);
      rd("compare value", ad(5, 3'(w)), d, 32'hffff);
    end
    // Cascade pair and lone half over one wrap
    wr(1, ocp_pkg::REG_CON2, 32'h100);
    wr(0, ocp_pkg::REG_CON2, 32'h100);
    wr(2, ocp_pkg::REG_CON2, 32'h100);
    wr(0, ocp_pkg::REG_CON1, 32'h6);
    wr(2, ocp_pkg::REG_CON1, 32'h6);
    apb(ad(0, ocp_pkg::REG_CNT), 1'b0, 32'h0, d, t);
    b = d - t;
    sync_pulse();
    repeat (70000) @(posedge ref_clk);
    rd("low half", ad(0, ocp_pkg::REG_CNT), b, 32'hffff, 1'b0, 1);
    rd("high half", ad(1, ocp_pkg::REG_CNT), b, 32'hffff, 1'b0, 1, 16);
    rd("lone half", ad(3, ocp_pkg::REG_CNT), 32'h0, '1);
    // Sync mode
    wr(3, ocp_pkg::REG_CON2, 32'ha);
    wr(3, ocp_pkg::REG_CON1, 32'h6);
    apb(ad(3, ocp_pkg::REG_CNT), 1'b0, 32'h0, d, t);
    b = d - t;
    rd("sync run", ad(3, ocp_pkg::REG_CNT), b, 32'hffff, 1'b0, 1);
    repeat (100) @(posedge ref_clk);
    sync_pulse();
    rd("sync reset", ad(3, ocp_pkg::REG_CNT), 32'h0, 32'hffc0);
    // Trigger mode
    wr(4, ocp_pkg::REG_CON2, 32'h8a);
    wr(4, ocp_pkg::REG_CON1, 32'h6);
    repeat (50) @(posedge ref_clk);
    rd("trigger hold", ad(4, ocp_pkg::REG_CNT), 32'h0, '1);
    rd("trigger idle", ad(4, ocp_pkg::REG_STAT), 32'h0, 32'h2);
    sync_pulse();
    apb(ad(4, ocp_pkg::REG_CNT), 1'b0, 32'h0, d, t);
    b = d - t;
    rd("trigger run", ad(4, ocp_pkg::REG_CNT), b, 32'hffff, 1'b0, 1);
    // External clock sources
    for (int s = 1; s < 6; s++)
    begin
      sb = 5'(1 << (s - 1));
      wr(6, ocp_pkg::REG_CON1, 32'(6 | (s << 4)));
      apb(ad(6, ocp_pkg::REG_CNT), 1'b0, 32'h0, d, t);
      for (int k = 0; k < 10; k++)
      begin
        @(posedge ref_clk);
        ext_clk_tick <= 5'($random(seed)) | sb;
        @(posedge ref_clk);
        ext_clk_tick <= 5'($random(seed)) & ~sb;
      end
      @(posedge ref_clk);
      ext_clk_tick <= 5'h00;
      rd("clock source", ad(6, ocp_pkg::REG_CNT), d + 32'd10, 32'hffff);
    end
    // Single pulse
    wr(7, ocp_pkg::REG_MAIN, 32'h5);
    wr(7, ocp_pkg::REG_SEC, 32'h8);
    eq.push_back(32'h3);
    wr(7, ocp_pkg::REG_CON1, 32'h5);
    repeat (40) @(posedge ref_clk);
    rd("single pulse", ad(7, ocp_pkg::REG_STAT), 32'h4, 32'h5);
    if (eq.size() > 0)
      n_mismatch++;
    // Buffered PWM with duty change in mid-pulse
    wr(8, ocp_pkg::REG_PER, 32'hf);
    wr(8, ocp_pkg::REG_MAIN, 32'h2);
    wr(8, ocp_pkg::REG_SEC, 32'ha);
    wr(8, ocp_pkg::REG_CON1, 32'h7);
    n = 0;
    while (rep_valid !== 1'b1 && n < 100)
    begin
      @(posedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    pq.push_back({16'd8, 16'd16});
    pq.push_back({16'd10, 16'd16});
    wr(8, ocp_pkg::REG_SEC, 32'hc);
    n = 0;
    while (pq.size() > 0 && n < 100)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 100)
      n_mismatch++;
    // Full and zero duty
    wr(8, ocp_pkg::REG_MAIN, 32'h0);
    wr(8, ocp_pkg::REG_SEC, 32'h14);
    for (int r = 0; r < 2; r++)
    begin
      repeat (30) @(posedge ref_clk);
      rd("full duty", ad(8, ocp_pkg::REG_STAT), 32'h1, 32'h1);
    end
    wr(8, ocp_pkg::REG_SEC, 32'h0);
    // Let the zero duty latch before the period shrinks below the count
    repeat (20) @(posedge ref_clk);
    wr(8, ocp_pkg::REG_PER, 32'h0);
    for (int r = 0; r < 2; r++)
    begin
      repeat (30) @(posedge ref_clk);
      rd("zero duty", ad(8, ocp_pkg::REG_STAT), 32'h0, 32'h1);
    end
    test_done();
  end
endmodule : test_output_compare_timer_pwm
